// ---- core/hirs_device.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "hirs_cfg.svh"

module hirs_device
    import hirs_pkg::*;
(
    input  wire logic        link_clk,
    input  wire logic        ref_clk,
    input  wire logic        rst,
    hirs_if.dev              bus,
    input  wire logic        port_en,
    input  wire logic        wr_mode,
    output logic             reg_wr_en,
    output logic             reg_rd_en,
    output logic [7:0]       reg_addr,
    output logic [7:0]       reg_wdata,
    input  wire logic [7:0]  reg_rdata,
    input  wire logic        reg_rd_hit
);

    hirs_link_s l;
    hirs_link_s next_l;
    hirs_ref_s  r;
    hirs_ref_s  next_r;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;
    logic [7:0] next_ptr;

    // Register pointer step, wraps in the 8-bit space
    function automatic logic [7:0] ptr_inc(input logic [7:0] p);
        ptr_inc = p + 8'h01;
    endfunction

    // Posts one register access to the reference side; dropped while one is still open
    function automatic hirs_link_s post_req(input hirs_link_s s, input logic we,
                                            input logic [7:0] a, input logic [7:0] d);
        post_req = s;
        if (s.req_tgl == s.ack_seen) begin
            post_req.req_tgl = ~s.req_tgl;
            post_req.req_we = we;
            post_req.req_addr = a;
            post_req.req_wdata = d;
        end
    endfunction

    // SDA only pulled low; no SCL driver exists at all
    assign bus.dev_sda_oe = l.sda_oe;
    assign bus.dev_sda_o  = 1'b0;
    assign reg_wr_en      = r.reg_wr_en;
    assign reg_rd_en      = r.reg_rd_en;
    assign reg_addr       = r.reg_addr;
    assign reg_wdata      = r.reg_wdata;

    // Link side: bus sampling, byte engine and acknowledge driver
    always_comb begin
        next_l = l;
        // two-flop sync, then a run-length filter on each line
        next_l.scl_s1 = bus.scl;
        next_l.scl_s2 = l.scl_s1;
        next_l.sda_s1 = bus.sda;
        next_l.sda_s2 = l.sda_s1;
        next_l.scl_h = {l.scl_h[`HIRS_FILT_LEN-2:0], l.scl_s2};
        next_l.sda_h = {l.sda_h[`HIRS_FILT_LEN-2:0], l.sda_s2};
        if (&next_l.scl_h) begin
            next_l.scl_f = 1'b1;
        end else if (~|next_l.scl_h) begin
            next_l.scl_f = 1'b0;
        end
        if (&next_l.sda_h) begin
            next_l.sda_f = 1'b1;
        end else if (~|next_l.sda_h) begin
            next_l.sda_f = 1'b0;
        end
        next_l.en_s1 = port_en;
        next_l.en_s2 = l.en_s1;
        next_l.mode_s1 = wr_mode;
        next_l.mode_s2 = l.mode_s1;
        next_l.ack_s1 = r.ack_tgl;
        next_l.ack_s2 = l.ack_s1;
        // bus edges come from the sampled lines, not from any internal timing
        scl_rise = next_l.scl_f & ~l.scl_f;
        scl_fall = ~next_l.scl_f & l.scl_f;
        // start and stop are SDA edges with SCL held high
        bus_start = l.scl_f & next_l.scl_f & l.sda_f & ~next_l.sda_f;
        bus_stop = l.scl_f & next_l.scl_f & ~l.sda_f & next_l.sda_f;
        next_ptr = l.mode_s2 ? l.ptr : ptr_inc(l.ptr);
        // Returned read data is stable once the toggle has crossed back
        if (l.ack_s2 != l.ack_seen) begin
            next_l.ack_seen = l.ack_s2;
            if (!l.req_we) begin
                next_l.rd_buf = r.rdata_x;
            end
        end
        // stop or a disabled port drops everything and releases SDA
        if (!l.en_s2 || bus_stop) begin
            next_l.state = D_IDLE;
            next_l.sda_oe = 1'b0;
            next_l.ack_on = 1'b0;
        end else if (bus_start) begin
            // a new start abandons the message and listens for an address
            next_l.state = D_ADDR;
            next_l.cnt = 3'd0;
            next_l.sda_oe = 1'b0;
            next_l.ack_on = 1'b0;
        end else if (scl_rise) begin
            unique case (l.state)
                D_ADDR, D_REG, D_WDATA: begin
                    next_l.sh = {l.sh[6:0], l.sda_f};
                    next_l.cnt = l.cnt + 3'd1;
                    if (l.cnt == `HIRS_LAST_BIT) begin
                        next_l.state = D_ACK;
                        if (l.state == D_ADDR) begin
                            // any other address leaves the bus alone
                            if (l.sh[6:0] != `HIRS_DEV_ADDR) begin
                                next_l.state = D_IDLE;
                            end else if (l.sda_f == `HIRS_RW_READ) begin
                                // fetch the pointed register ahead of the first bit
                                next_l.kind = K_ADDR_R;
                                next_l = post_req(next_l, 1'b0, l.ptr, 8'h00);
                            end else begin
                                next_l.kind = K_ADDR_W;
                            end
                        end else if (l.state == D_REG) begin
                            next_l.kind = K_REG;
                        end else begin
                            next_l.kind = K_DATA;
                        end
                    end
                end
                D_MACK: begin
                    if (l.sda_f) begin
                        // Master NAK: wait for the stop
                        next_l.state = D_IDLE;
                    end else begin
                        // acknowledged, so step (mode 0) and fetch the next byte
                        // mode 1 rereads the same register
                        next_l.state = D_RNEXT;
                        next_l.ptr = next_ptr;
                        next_l = post_req(next_l, 1'b0, next_ptr, 8'h00);
                    end
                end
                D_IDLE, D_ACK, D_RDATA, D_RNEXT: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (l.state)
                D_ACK: begin
                    if (!l.ack_on) begin
                        // hold SDA low through the acknowledge clock
                        // every byte addressed to us is acknowledged
                        next_l.ack_on = 1'b1;
                        next_l.sda_oe = 1'b1;
                    end else begin
                        next_l.ack_on = 1'b0;
                        next_l.sda_oe = 1'b0;
                        next_l.cnt = 3'd0;
                        unique case (l.kind)
                            K_ADDR_W: next_l.state = D_REG;
                            K_ADDR_R: begin
                                next_l.state = D_RDATA;
                                next_l.sh = l.rd_buf;
                                next_l.sda_oe = ~l.rd_buf[7];
                            end
                            K_REG: begin
                                next_l.ptr = l.sh;
                                next_l.state = D_WDATA;
                            end
                            K_DATA: begin
                                // commit only once the acknowledge clock is over
                                next_l = post_req(next_l, 1'b1, l.ptr, l.sh);
                                if (l.mode_s2) begin
                                    // next byte is again a register address
                                    next_l.state = D_REG;
                                end else begin
                                    next_l.ptr = ptr_inc(l.ptr);
                                    next_l.state = D_WDATA;
                                end
                            end
                        endcase
                    end
                end
                D_RDATA: begin
                    // drive MSB first; a one is a released line
                    if (l.cnt == `HIRS_LAST_BIT) begin
                        next_l.sda_oe = 1'b0;
                        next_l.state = D_MACK;
                    end else begin
                        next_l.cnt = l.cnt + 3'd1;
                        next_l.sh = {l.sh[6:0], 1'b0};
                        next_l.sda_oe = ~l.sh[6];
                    end
                end
                D_RNEXT: begin
                    next_l.state = D_RDATA;
                    next_l.cnt = 3'd0;
                    next_l.sh = l.rd_buf;
                    next_l.sda_oe = ~l.rd_buf[7];
                end
                D_IDLE, D_ADDR, D_REG, D_WDATA, D_MACK: begin
                end
            endcase
        end
    end

    // Link state register; lines come out of reset as an idle bus
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            l <= '0;
            l.scl_h <= '1;
            l.sda_h <= '1;
            l.scl_f <= `HIRS_LINE_IDLE;
            l.sda_f <= `HIRS_LINE_IDLE;
            l.scl_s1 <= `HIRS_LINE_IDLE;
            l.scl_s2 <= `HIRS_LINE_IDLE;
            l.sda_s1 <= `HIRS_LINE_IDLE;
            l.sda_s2 <= `HIRS_LINE_IDLE;
        end else begin
            l <= next_l;
        end
    end

    // Reference side: performs each posted access, answers with a toggle
    always_comb begin
        next_r = r;
        next_r.reg_wr_en = 1'b0;
        next_r.reg_rd_en = 1'b0;
        next_r.rq_s1 = l.req_tgl;
        next_r.rq_s2 = r.rq_s1;
        if (r.rd_wait) begin
            // a missing register answers zero and the read goes on
            next_r.rdata_x = reg_rd_hit ? reg_rdata : `HIRS_RD_MISS;
            next_r.ack_tgl = ~r.ack_tgl;
            next_r.rd_wait = 1'b0;
        end else if (r.rq_s2 != r.rq_seen) begin
            // Request fields are held by the link side until the toggle returns
            next_r.rq_seen = r.rq_s2;
            next_r.reg_addr = l.req_addr;
            next_r.reg_wdata = l.req_wdata;
            if (l.req_we) begin
                next_r.reg_wr_en = 1'b1;
                next_r.ack_tgl = ~r.ack_tgl;
            end else begin
                next_r.reg_rd_en = 1'b1;
                next_r.rd_wait = 1'b1;
            end
        end
    end

    // Reference state register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

endmodule

`default_nettype wire

// ---- core/hirs_cfg.svh ----
`ifndef HIRS_CFG_SVH
`define HIRS_CFG_SVH

// Fixed 7-bit bus address of the device
`define HIRS_DEV_ADDR      7'h4A
// Direction bit that follows the address
`define HIRS_RW_WRITE      1'b0
`define HIRS_RW_READ       1'b1
// Bits per byte on the bus
`define HIRS_BYTE_BITS     8
// Last bit index within a byte
`define HIRS_LAST_BIT      3'h7
// Glitch filter length in link clock samples
`define HIRS_FILT_LEN      3
// Level of an idle bus line after reset
`define HIRS_LINE_IDLE     1'b1
// Fastest bus clock in kHz and reference clock in MHz
`define HIRS_SCL_MAX_KHZ   1000
`define HIRS_REF_MHZ       250
// Quarter bit period in reference cycles, rounded up so the bus never exceeds its top rate
`define HIRS_QTR_CYC       ((`HIRS_REF_MHZ * 1000 + 4 * `HIRS_SCL_MAX_KHZ - 1) / (4 * `HIRS_SCL_MAX_KHZ))
// Value returned for a register that does not exist
`define HIRS_RD_MISS       8'h00

`endif

// ---- core/hirs_pkg.sv ----
`include "hirs_cfg.svh"

package hirs_pkg;

    // Device byte engine states
    typedef enum logic [2:0] {
        D_IDLE,
        D_ADDR,
        D_REG,
        D_WDATA,
        D_ACK,
        D_RDATA,
        D_MACK,
        D_RNEXT
    } hirs_dev_e;

    // What the byte under acknowledge was
    typedef enum logic [1:0] {
        K_ADDR_W,
        K_ADDR_R,
        K_REG,
        K_DATA
    } hirs_kind_e;

    // Host bit engine states
    typedef enum logic [1:0] {
        H_IDLE,
        H_START,
        H_BIT,
        H_STOP
    } hirs_host_e;

    // Device state on the link clock
    typedef struct packed {
        logic                        scl_s1;
        logic                        scl_s2;
        logic                        sda_s1;
        logic                        sda_s2;
        logic [`HIRS_FILT_LEN-1:0]   scl_h;
        logic [`HIRS_FILT_LEN-1:0]   sda_h;
        logic                        scl_f;
        logic                        sda_f;
        logic                        en_s1;
        logic                        en_s2;
        logic                        mode_s1;
        logic                        mode_s2;
        logic                        ack_s1;
        logic                        ack_s2;
        logic                        ack_seen;
        hirs_dev_e                   state;
        hirs_kind_e                  kind;
        logic                        ack_on;
        logic [2:0]                  cnt;
        logic [7:0]                  sh;
        logic [7:0]                  ptr;
        logic [7:0]                  rd_buf;
        logic                        req_tgl;
        logic                        req_we;
        logic [7:0]                  req_addr;
        logic [7:0]                  req_wdata;
        logic                        sda_oe;
    } hirs_link_s;

    // Device state on the reference clock
    typedef struct packed {
        logic                        rq_s1;
        logic                        rq_s2;
        logic                        rq_seen;
        logic                        rd_wait;
        logic                        ack_tgl;
        logic [7:0]                  rdata_x;
        logic [7:0]                  reg_addr;
        logic [7:0]                  reg_wdata;
        logic                        reg_wr_en;
        logic                        reg_rd_en;
    } hirs_ref_s;

    // Host state
    typedef struct packed {
        hirs_host_e                  state;
        logic [7:0]                  qcnt;
        logic [1:0]                  q;
        logic [3:0]                  bitn;
        logic [1:0]                  step;
        logic                        rd;
        logic [7:0]                  reg_a;
        logic [7:0]                  wdata;
        logic [7:0]                  sh;
        logic [7:0]                  rx;
        logic                        nak;
        logic                        sda_s1;
        logic                        sda_s2;
        logic                        scl_oe;
        logic                        sda_oe;
        logic                        cmd_ready;
        logic                        rsp_valid;
        logic [7:0]                  rsp_data;
        logic                        rsp_nak;
    } hirs_host_s;

endpackage

// ---- core/hirs_if.sv ----
`timescale 1ns/1ns
`default_nettype none

interface hirs_if;
    logic host_scl_oe;
    logic host_scl_o;
    logic host_sda_oe;
    logic host_sda_o;
    logic dev_sda_oe;
    logic dev_sda_o;
    logic scl;
    logic sda;

    // Open-drain lines: low when any enabled driver pulls low, else the pull-up wins
    assign scl = ~(host_scl_oe & ~host_scl_o);
    assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

    modport host (
        output host_scl_oe,
        output host_scl_o,
        output host_sda_oe,
        output host_sda_o,
        input  scl,
        input  sda
    );

    modport dev (
        output dev_sda_oe,
        output dev_sda_o,
        input  scl,
        input  sda
    );
endinterface

`default_nettype wire

// ---- core/hirs_host.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "hirs_cfg.svh"

module hirs_host
    import hirs_pkg::*;
#(
    parameter int unsigned QTR_CYC = `HIRS_QTR_CYC
) (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    hirs_if.host             bus,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire logic        cmd_read,
    input  wire logic [7:0]  cmd_reg,
    input  wire logic [7:0]  cmd_wdata,
    output logic             rsp_valid,
    output logic [7:0]       rsp_data,
    output logic             rsp_nak
);

    hirs_host_s h;
    hirs_host_s next_h;
    logic       tick;
    logic       tx;

    // Only pulls low or releases; the line is never driven high
    assign bus.host_scl_oe = h.scl_oe;
    assign bus.host_scl_o  = 1'b0;
    assign bus.host_sda_oe = h.sda_oe;
    assign bus.host_sda_o  = 1'b0;
    assign cmd_ready       = h.cmd_ready;
    assign rsp_valid       = h.rsp_valid;
    assign rsp_data        = h.rsp_data;
    assign rsp_nak         = h.rsp_nak;

    // Quarter-bit sequencer: q0 set data, q1 raise clock, q2 sample (start/stop move SDA here), q3 drop clock (stop leaves it high)
    always_comb begin
        next_h = h;
        tick = (h.qcnt == 8'(QTR_CYC - 1));
        tx = (h.step != 2'd3);
        next_h.rsp_valid = 1'b0;
        next_h.sda_s1 = bus.sda;
        next_h.sda_s2 = h.sda_s1;
        next_h.qcnt = tick ? 8'h00 : h.qcnt + 8'h01;
        if (tick && h.state != H_IDLE) begin
            next_h.q = h.q + 2'd1;
        end
        unique case (h.state)
            H_IDLE: begin
                next_h.qcnt = 8'h00;
                next_h.q = 2'd0;
                if (cmd_valid && h.cmd_ready) begin
                    next_h.cmd_ready = 1'b0;
                    next_h.rd = cmd_read;
                    next_h.reg_a = cmd_reg;
                    next_h.wdata = cmd_wdata;
                    next_h.step = 2'd0;
                    next_h.nak = 1'b0;
                    next_h.rx = 8'h00;
                    next_h.state = H_START;
                end
            end
            H_START: if (tick) begin
                unique case (h.q)
                    2'd0: next_h.sda_oe = 1'b0;
                    2'd1: next_h.scl_oe = 1'b0;
                    2'd2: next_h.sda_oe = 1'b1;
                    2'd3: begin
                        next_h.scl_oe = 1'b1;
                        next_h.bitn = 4'd0;
                        next_h.sh = {`HIRS_DEV_ADDR, (h.step == 2'd0) ? `HIRS_RW_WRITE : `HIRS_RW_READ};
                        next_h.state = H_BIT;
                    end
                endcase
            end
            // eight bits, MSB first, then the acknowledge slot
            H_BIT: if (tick) begin
                unique case (h.q)
                    2'd0: next_h.sda_oe = (tx && h.bitn < 4'd8) ? ~h.sh[7] : 1'b0;
                    2'd1: next_h.scl_oe = 1'b0;
                    2'd2: begin
                        if (h.bitn < 4'd8 && !tx) begin
                            next_h.rx = {h.rx[6:0], h.sda_s2};
                        end else if (h.bitn == 4'd8 && tx) begin
                            next_h.nak = h.nak | h.sda_s2;
                        end
                    end
                    2'd3: begin
                        next_h.scl_oe = 1'b1;
                        if (h.bitn < 4'd8) begin
                            next_h.sh = {h.sh[6:0], 1'b0};
                            next_h.bitn = h.bitn + 4'd1;
                        end else begin
                            next_h.bitn = 4'd0;
                            // register address, then the data byte, or repeated start and read
                            if (h.nak || h.step == 2'd3) begin
                                next_h.state = H_STOP;
                            end else if (h.step == 2'd0) begin
                                next_h.step = 2'd1;
                                next_h.sh = h.reg_a;
                            end else if (h.step == 2'd1) begin
                                next_h.step = 2'd2;
                                next_h.sh = h.wdata;
                                if (h.rd) begin
                                    next_h.state = H_START;
                                end
                            end else if (h.rd) begin
                                next_h.step = 2'd3;
                            end else begin
                                next_h.state = H_STOP;
                            end
                        end
                    end
                endcase
            end
            H_STOP: if (tick) begin
                unique case (h.q)
                    2'd0: next_h.sda_oe = 1'b1;
                    2'd1: next_h.scl_oe = 1'b0;
                    2'd2: next_h.sda_oe = 1'b0;
                    2'd3: begin
                        next_h.rsp_valid = 1'b1;
                        next_h.rsp_data = h.rd ? h.rx : `HIRS_RD_MISS;
                        next_h.rsp_nak = h.nak;
                        next_h.cmd_ready = 1'b1;
                        next_h.state = H_IDLE;
                    end
                endcase
            end
        endcase
    end

    // State register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            h <= '0;
            h.sda_s1 <= `HIRS_LINE_IDLE;
            h.sda_s2 <= `HIRS_LINE_IDLE;
            h.cmd_ready <= 1'b1;
        end else begin
            h <= next_h;
        end
    end

endmodule

`default_nettype wire

// ---- dv/hirs_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module hirs_properties (
    input wire logic link_clk,
    input wire logic rst,
    input wire logic host_scl_o,
    input wire logic host_scl_oe,
    input wire logic host_sda_o,
    input wire logic host_sda_oe,
    input wire logic dev_sda_o,
    input wire logic dev_sda_oe,
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge link_clk); endclocking
    default disable iff (rst);
    // Start and stop as seen on the resolved lines
    sequence s_start; scl && $fell(sda); endsequence
    sequence s_stop; scl && $rose(sda); endsequence
    // Device pulls change only while SCL is low, and hold for at least eight link clocks
    a_drive_low: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
        else $error("line driven high");
    a_scl_master: assert property (scl == !host_scl_oe)
        else $error("scl not from master");
    a_sda_wired: assert property (sda == !(host_sda_oe || dev_sda_oe))
        else $error("sda level wrong");
    a_dev_edges: assert property ($changed(dev_sda_oe) |-> !scl)
        else $error("sda moved with scl high");
    a_dev_hold: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
        else $error("pull too short");
    a_dev_bound: assert property ($rose(dev_sda_oe) |-> ##[1:500] !dev_sda_oe)
        else $error("pull never released");
    a_stop_idle: assert property (s_stop |-> !dev_sda_oe [*8])
        else $error("active after stop");
    a_start_idle: assert property (s_start |-> !dev_sda_oe [*4])
        else $error("active at start");
endmodule
`default_nettype wire

// ---- dv/tb_haptic_i2c_register_slave.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_haptic_i2c_register_slave;
    logic ref_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, port_en = 1'b1, wr_mode = 1'b0;
    logic cmd_valid = 1'b0, cmd_read = 1'b0, reg_rd_hit;
    logic cmd_ready, rsp_valid, rsp_nak, reg_wr_en, reg_rd_en;
    logic [7:0] cmd_reg = 8'h00, cmd_wdata = 8'h00, reg_rdata;
    logic [7:0] rsp_data, reg_addr, reg_wdata;
    logic [7:0] mem [32] = '{default: 8'h00};
    logic [7:0] pat [3] = '{8'h80, 8'h01, 8'hFF};
    int err_total = 0, num_checks = 0, rd_cnt = 0;
    hirs_if bus ();
    // Clocks of unrelated phase
    always #2 ref_clk = ~ref_clk;
    always #3 link_clk = ~link_clk;
    hirs_host #(.QTR_CYC(16)) i_hirs_host (.ref_clk, .rst, .bus(bus.host), .cmd_valid, .cmd_ready,
        .cmd_read, .cmd_reg, .cmd_wdata, .rsp_valid, .rsp_data, .rsp_nak);
    hirs_device i_hirs_device (.link_clk, .ref_clk, .rst, .bus(bus.dev), .port_en, .wr_mode,
        .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wdata, .reg_rdata, .reg_rd_hit);
    hirs_properties i_hirs_properties (.link_clk, .rst, .host_scl_o(bus.host_scl_o),
        .host_scl_oe(bus.host_scl_oe), .host_sda_o(bus.host_sda_o), .host_sda_oe(bus.host_sda_oe),
        .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe), .scl(bus.scl), .sda(bus.sda));
    // Register file: 32 entries, higher addresses miss; read data follows the held address at once
    assign reg_rdata = mem[reg_addr[4:0]];
    assign reg_rd_hit = (reg_addr < 8'h20);
    always @(posedge ref_clk) begin
        if (reg_wr_en === 1'b1) mem[reg_addr[4:0]] <= reg_wdata;
        if (reg_rd_en === 1'b1) rd_cnt++;
    end
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Response is sampled on the falling edge, clear of flop updates
    task automatic xfer(input logic rd, input logic [7:0] ra, input logic [7:0] wd);
        int n = 0;
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_reg <= ra;
        cmd_wdata <= wd;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        do @(negedge ref_clk); while (rsp_valid !== 1'b1 && ++n < 8000);
        if (n >= 8000) begin
            err_total++;
            $display("ERROR response expected 1 seen 0");
        end
    endtask
    task automatic wr(input logic [7:0] ra, input logic [7:0] wd);
        xfer(1'b0, ra, wd);
        chk("write nak", 8'h00, {7'h00, rsp_nak});
    endtask
    task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
        xfer(1'b1, ra, 8'h00);
        chk("read nak", 8'h00, {7'h00, rsp_nak});
        chk("read data", exp, rsp_data);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (20) @(posedge ref_clk);
        wr(8'h10, 8'h55);
        chk("stored", 8'h55, mem[16]);
        rd(8'h10, 8'h55);
        foreach (pat[i]) begin
            wr(8'h1F, pat[i]);
            rd(8'h1F, pat[i]);
        end
        rd(8'h80, 8'h00);
        @(posedge ref_clk) wr_mode <= 1'b1;
        wr(8'h03, 8'hA5);
        rd(8'h03, 8'hA5);
        chk("neighbour", 8'h00, mem[4]);
        @(posedge ref_clk) port_en <= 1'b0;
        xfer(1'b0, 8'h10, 8'h00);
        chk("off nak", 8'h01, {7'h00, rsp_nak});
        chk("kept", 8'h55, mem[16]);
        @(posedge ref_clk) port_en <= 1'b1;
        repeat (20) @(posedge ref_clk);
        rd(8'h10, 8'h55);
        // One register fetch per read, none after the master's NAK
        chk("read strobes", 8'h07, rd_cnt[7:0]);
        wrap_up();
    end
    // Watchdog well beyond the thirteen transfers above
    initial begin
        #300000;
        err_total++;
        $display("ERROR watchdog expected done seen timeout");
        wrap_up();
    end
endmodule
`default_nettype wire
